//--- hw/ssr_pkg.sv
// Package of constants and types for the SPI status-report slave
package ssr_pkg;
    localparam int SSR_BYTE_W    = 8;
    localparam int SSR_NUM_STAT  = 4;  // Status registers targeted by faults
    localparam int SSR_IDX_W     = 2;
    localparam logic [2:0] SSR_BIT_LAST = 3'h7;
    // Address byte fields, LSB first on the wire
    localparam int SSR_ADR_ONE   = 0;
    localparam int SSR_ADR_LAST_ADDRESS_TOKEN  = 1;
    localparam int SSR_ADR_LO    = 2;
    localparam int SSR_ADR_HI    = 6;
    localparam int SSR_ADR_OP    = 7;
    // Global status bit positions
    localparam int SSR_GS_LE     = 6;
    localparam int SSR_GS_ERR    = 7;
    // Status register addresses (A6..A2)
    localparam logic [4:0] SSR_A_DIAG1 = 5'h0c;
    localparam logic [4:0] SSR_A_DIAG2 = 5'h0d;
    localparam logic [4:0] SSR_A_DIAG3 = 5'h0e;
    localparam logic [4:0] SSR_A_DIAG5 = 5'h10;
    localparam logic [4:0] SSR_NO_HIT  = 5'h1f;

    typedef struct packed {
        logic       err_flag;    // global_error_flag source
        logic [5:0] misc;        // Bits 1..5 of global status, load error 6
        logic       unused;
    } ssr_dummy_t;

    typedef struct packed {
        logic [4:0] addr;
        logic       op_clear;    // operation_select
        logic       last_token;  // last_address_token
    } ssr_cmd_t;

    typedef enum logic [1:0] {
        SSR_IDLE,
        SSR_ADDR,
        SSR_DATA
    } ssr_phase_t;
endpackage

//--- hw/ssr_status_slave.sv
// SPI status-report slave with daisy-chain global error flag
`timescale 1ns/1ps
// Contract
// - Zero-clock frame shows error flag ORed
// - Bad address LSB flags protocol error
// - Late faults reported next frame
// - New fault during clear cancels clear
// - Data-byte fault shows in response byte
// - Global load error unchanged until next
// - Flag then global status, LSB first
// - Chain forwards status then responses reversed
module ssr_status_slave
    import ssr_pkg::*;
#(
    parameter int NSTAT = ssr_pkg::SSR_NUM_STAT
) (
    input  wire logic                         clk_sys_in,
    input  wire logic                         nrst_in,
    input  wire logic                         spi_ncs_in,
    input  wire logic                         spi_sclk_in,
    input  wire logic                         spi_sdi_in,
    output logic                              spi_sdo_out,
    output logic                              spi_sdo_oe_out,
    input  wire logic [NSTAT-1:0][SSR_BYTE_W-1:0] fault_set_in,
    input  wire logic [5:1]                   glob_misc_in,
    input  wire logic                         por_done_in,
    output logic [NSTAT-1:0][SSR_BYTE_W-1:0]  status_out,
    output logic                              protocol_err_out,
    output logic                              load_error_flag_out,
    output logic                              global_error_flag_out
);
    import ssr_pkg::*;

    logic [2:0] pins_s;
    logic       ncs_s, sclk_s, sdi_s, ncs_p_q, sclk_p_q;
    ssr_sync #(.W(3)) u_sync (
        .clk_sys_in (clk_sys_in),
        .nrst_in    (nrst_in),
        .d_in       ({~spi_ncs_in, spi_sclk_in, spi_sdi_in}),
        .rst_val_in (3'h0),
        .q_out      (pins_s)
    );
    // Inverted so the synchroniser's reset value reads as deselected
    assign ncs_s  = ~pins_s[2];
    assign sclk_s = pins_s[1];
    assign sdi_s  = pins_s[0];

    logic cs_fall, cs_rise, sck_rise, sck_fall;
    always_ff @(posedge clk_sys_in or negedge nrst_in)
    begin
        if (!nrst_in)
        begin
            ncs_p_q  <= 1'b1;
            sclk_p_q <= 1'b0;
        end
        else
        begin
            ncs_p_q  <= ncs_s;
            sclk_p_q <= sclk_s;
        end
    end
    assign cs_fall  = ncs_p_q & ~ncs_s;
    assign cs_rise  = ~ncs_p_q & ncs_s;
    assign sck_rise = ~ncs_s & ~sclk_p_q & sclk_s;
    assign sck_fall = ~ncs_s & sclk_p_q & ~sclk_s;

    // Frame bookkeeping
    ssr_phase_t      phase_q;
    logic [2:0]      bit_q;
    logic [7:0]      shin_q, shout_q, pend_q;
    logic [7:0]      bytes_q;
    logic            have_pend_q, clk_err_q, bad_q;
    ssr_cmd_t        cmd_q;
    logic            cmd_ok_q;
    logic [7:0]      first_byte;
    assign first_byte = {sdi_s, shin_q[7:1]};

    // Status registers and fault capture during the frame
    logic [NSTAT-1:0][7:0] stat_q, new_q;
    logic            spi_err_q, le_snap_q;
    logic [SSR_IDX_W-1:0] tidx;
    logic            thit;
    always_comb
    begin
        thit = 1'b1;
        tidx = '0;
        case (cmd_q.addr)
            SSR_A_DIAG2: tidx = SSR_IDX_W'(0);
            SSR_A_DIAG3: tidx = SSR_IDX_W'(1);
            SSR_A_DIAG5: tidx = SSR_IDX_W'(2);
            SSR_A_DIAG1: tidx = SSR_IDX_W'(3);
            default:     thit = 1'b0;
        endcase
    end

    logic le_now;
    assign le_now = |stat_q[0] | |stat_q[1] | |stat_q[2];
    logic [7:0] gstat;
    assign gstat = {spi_err_q, le_snap_q, glob_misc_in[4:3],
                    por_done_in, glob_misc_in[2:1], 1'b0};
    // Top misc bit has no status slot; it only raises the flag
    assign global_error_flag_out = spi_err_q | le_now | (|glob_misc_in)
                                   | ~por_done_in;
    logic resp_on;
    assign resp_on = phase_q == SSR_DATA && bytes_q == 8'h1 && thit
                     && cmd_ok_q;
    assign load_error_flag_out   = le_snap_q;
    assign protocol_err_out      = spi_err_q;
    assign status_out            = stat_q;

    // Serial output: flag first, then status, then forwarded stream
    always_ff @(posedge clk_sys_in or negedge nrst_in)
    begin
        if (!nrst_in)
        begin
            phase_q <= SSR_IDLE;
            bit_q   <= '0;
            shin_q  <= '0;
            shout_q <= '0;
            bytes_q <= '0;
            cmd_q   <= '0;
            cmd_ok_q <= 1'b0;
            bad_q   <= 1'b0;
            clk_err_q <= 1'b0;
            pend_q  <= '0;
            have_pend_q <= 1'b0;
            spi_sdo_out <= 1'b0;
        end
        else if (cs_fall)
        begin
            phase_q <= SSR_ADDR;
            bit_q   <= '0;
            bytes_q <= '0;
            bad_q   <= 1'b0;
            clk_err_q <= sclk_s;
            have_pend_q <= 1'b0;
            // Flag alone at frame start; the OR with upstream SDI follows until the first clock
            spi_sdo_out <= global_error_flag_out;
            shout_q <= {1'b0, gstat[7:1]};
        end
        else if (phase_q != SSR_IDLE && cs_rise)
        begin
            phase_q <= SSR_IDLE;
        end
        else if (phase_q != SSR_IDLE)
        begin
            if (sck_rise)
            begin
                shin_q <= first_byte;
                bit_q  <= bit_q + 3'h1;
                if (bit_q == SSR_BIT_LAST)
                begin
                    bytes_q <= bytes_q + 8'h1;
                    if (phase_q == SSR_ADDR)
                    begin
                        // Own address is the first; later ones pass on
                        if (bytes_q == 8'h0)
                        begin
                            cmd_q <= {first_byte[SSR_ADR_HI:SSR_ADR_LO],
                                      first_byte[SSR_ADR_OP],
                                      first_byte[SSR_ADR_LAST_ADDRESS_TOKEN]};
                            cmd_ok_q <= first_byte[SSR_ADR_ONE];
                        end
                        if (!first_byte[SSR_ADR_ONE])
                            bad_q <= 1'b1;
                        // Token ends address phase for the whole chain
                        if (first_byte[SSR_ADR_LAST_ADDRESS_TOKEN])
                            phase_q <= SSR_DATA;
                    end
                    pend_q <= first_byte;
                    have_pend_q <= 1'b1;
                end
            end
            else if (sck_fall)
            begin
                // Live register so data-byte faults reach the response
                if (resp_on)
                    spi_sdo_out <= stat_q[tidx][bit_q];
                else if (bit_q == 3'h0)
                    spi_sdo_out <= have_pend_q & pend_q[0];
                else
                    spi_sdo_out <= shout_q[0];
                if (bit_q == 3'h0)
                    shout_q <= {1'b0, pend_q[7:1]};
                else
                    shout_q <= {1'b0, shout_q[7:1]};
            end
            else if (phase_q == SSR_ADDR && bytes_q == 8'h0
                     && bit_q == 3'h0)
            begin
                // Until the first clock the flag is ORed with upstream
                spi_sdo_out <= global_error_flag_out | sdi_s;
            end
        end
    end
    assign spi_sdo_oe_out = ~ncs_s;

    // Fault latching, clear handling, deferred global load error
    genvar g;
    generate
        for (g = 0; g < NSTAT; g++)
        begin : g_stat
            logic hit_g;
            assign hit_g = thit && tidx == SSR_IDX_W'(g);
            always_ff @(posedge clk_sys_in or negedge nrst_in)
            begin
                if (!nrst_in)
                begin
                    stat_q[g] <= '0;
                    new_q[g]  <= '0;
                end
                else
                begin
                    if (cs_fall)
                        new_q[g] <= fault_set_in[g];
                    else
                        new_q[g] <= new_q[g] | fault_set_in[g];
                    if (cs_rise && cmd_q.op_clear && cmd_ok_q && hit_g
                        && !bad_q && ~|(new_q[g] | fault_set_in[g]))
                        stat_q[g] <= fault_set_in[g];
                    else
                        stat_q[g] <= stat_q[g] | fault_set_in[g];
                end
            end
        end
    endgenerate

    always_ff @(posedge clk_sys_in or negedge nrst_in)
    begin
        if (!nrst_in)
        begin
            spi_err_q <= 1'b0;
            le_snap_q <= 1'b0;
        end
        else
        begin
            // Snapshot tracks while idle and freezes at frame start, keeping this frame's status fixed
            if (cs_fall || phase_q == SSR_IDLE)
                le_snap_q <= le_now;
            if (cs_rise && phase_q != SSR_IDLE)
            begin
                // Sticky until cleared; a new error wins over the clear
                if (bad_q || clk_err_q || sclk_s || bit_q != 3'h0
                    || (bytes_q != 8'h0 && bytes_q < 8'h2))
                    spi_err_q <= 1'b1;
                else if (cmd_q.op_clear && cmd_ok_q
                         && cmd_q.addr == SSR_A_DIAG1)
                    spi_err_q <= 1'b0;
            end
        end
    end
endmodule // ssr_status_slave

//--- hw/ssr_sync.sv
// Two-flop synchroniser bank for pin inputs
`timescale 1ns/1ps
module ssr_sync #(
    parameter int W = 3
) (
    input  wire logic         clk_sys_in,
    input  wire logic         nrst_in,
    input  wire logic [W-1:0] d_in,
    input  wire logic [W-1:0] rst_val_in,
    output logic      [W-1:0] q_out
);
    logic [W-1:0] meta_q;
    genvar g;
    generate
        for (g = 0; g < W; g++)
        begin : g_bit
            always_ff @(posedge clk_sys_in or negedge nrst_in)
            begin
                if (!nrst_in)
                begin
                    meta_q[g] <= 1'b0;
                    q_out[g]  <= 1'b0;
                end
                else
                begin
                    meta_q[g] <= d_in[g];
                    q_out[g]  <= meta_q[g];
                end
            end
        end
    endgenerate
endmodule // ssr_sync

//--- tb/ssr_checker.sv
// Port assertions for the status-report slave
`timescale 1ns/1ps
module ssr_checker #(
    parameter int NSTAT = ssr_pkg::SSR_NUM_STAT
) (
    input wire logic clk_sys_in,
    input wire logic nrst_in,
    input wire logic spi_ncs_in,
    input wire logic spi_sclk_in,
    input wire logic spi_sdo_out,
    input wire logic spi_sdo_oe_out,
    input wire logic [NSTAT-1:0][ssr_pkg::SSR_BYTE_W-1:0] fault_set_in,
    input wire logic [NSTAT-1:0][ssr_pkg::SSR_BYTE_W-1:0] status_out,
    input wire logic protocol_err_out,
    input wire logic global_error_flag_out
);
    import ssr_pkg::*;
    default clocking @(posedge clk_sys_in); endclocking
    default disable iff (!nrst_in);
    oe_idle_a:
        assert property (spi_ncs_in [*4] |-> !spi_sdo_oe_out)
        else $error("sdo driven while deselected");
    oe_frame_a:
        assert property ((!spi_ncs_in) [*4] |-> spi_sdo_oe_out)
        else $error("sdo not driven in frame");
    zero_flag_a:
        assert property ($fell(spi_ncs_in) ##1 (!spi_sclk_in) [*8]
            |-> ##[0:4] spi_sdo_out == global_error_flag_out)
        else $error("flag missing at frame start");
    err_flag_a:
        assert property (protocol_err_out |-> global_error_flag_out)
        else $error("protocol error not in flag");
    err_hold_a:
        assert property (!spi_ncs_in && spi_sclk_in
            |-> $stable(protocol_err_out))
        else $error("protocol error moved mid bit");
    fault_set_a:
        assert property (fault_set_in[0][1] [*2] |-> ##[0:3] status_out[0][1])
        else $error("fault not captured");
    fault_keep_a:
        assert property (fault_set_in[0][1] && status_out[0][1]
            |-> ##[1:3] status_out[0][1])
        else $error("fault lost while present");
    sdo_hold_a:
        assert property (spi_sclk_in [*6] |-> $stable(spi_sdo_out))
        else $error("sdo moved while clock high");
endmodule // ssr_checker

bind ssr_status_slave ssr_checker #(.NSTAT(NSTAT)) ssr_checker_i (
    .clk_sys_in, .nrst_in, .spi_ncs_in, .spi_sclk_in, .spi_sdo_out,
    .spi_sdo_oe_out, .fault_set_in, .status_out, .protocol_err_out,
    .global_error_flag_out);

//--- tb/ssr_spi_master.sv
// SPI master model for the status-report slave
`timescale 1ns/1ps
module ssr_spi_master (
    input  wire logic clk_sys_in,
    input  wire logic sdo_in,
    output logic      ncs_out,
    output logic      sclk_out,
    output logic      sdi_out
);
    initial
    begin
        ncs_out = 1'b1;
        sclk_out = 1'b0;
        sdi_out = 1'b1;
    end
    // Frame of nbit clocks, LSB first; rx[0] is the flag
    task automatic xfer(input logic [15:0] tx, input int nbit,
                        output logic [15:0] rx);
        rx = '0;
        @(negedge clk_sys_in);
        ncs_out <= 1'b0;
        sdi_out <= 1'b0;
        repeat (8) @(negedge clk_sys_in);
        rx[0] = sdo_in;
        for (int i = 0; i < nbit; i++)
        begin
            sdi_out <= tx[i];
            repeat (8) @(negedge clk_sys_in);
            sclk_out <= 1'b1;
            // Flag taken before SDI left its low level
            if (i > 0)
                rx[i] = sdo_in;
            repeat (8) @(negedge clk_sys_in);
            sclk_out <= 1'b0;
        end
        repeat (8) @(negedge clk_sys_in);
        ncs_out <= 1'b1;
        // Released line shows no stale level
        sdi_out <= ~sdi_out;
        repeat (16) @(negedge clk_sys_in);
    endtask
endmodule // ssr_spi_master

//--- tb/ssr_status_slave_test.sv
// Self-checking bench for the status-report slave
`timescale 1ns/1ps
module ssr_status_slave_test;
    import ssr_pkg::*;
    logic clk_sys_in, nrst_in, ncs, sclk, sdi, sdo, oe, por_done_in;
    logic [SSR_NUM_STAT-1:0][SSR_BYTE_W-1:0] fault_set_in, stat;
    logic [5:1]  glob_misc_in;
    logic        perr, lerr, gerr;
    logic [15:0] r;
    int errors = 0;
    int n_tests = 0;
    ssr_status_slave ssr_status_slave_i (
        .clk_sys_in, .nrst_in, .spi_ncs_in(ncs), .spi_sclk_in(sclk),
        .spi_sdi_in(sdi), .spi_sdo_out(sdo), .spi_sdo_oe_out(oe),
        .fault_set_in, .glob_misc_in, .por_done_in, .status_out(stat),
        .protocol_err_out(perr), .load_error_flag_out(lerr),
        .global_error_flag_out(gerr));
    ssr_spi_master ssr_spi_master_i (.clk_sys_in, .sdo_in(sdo),
        .ncs_out(ncs), .sclk_out(sclk), .sdi_out(sdi));
    task automatic chk(input string nm, input logic [7:0] e, logic [7:0] g);
        n_tests++;
        if (g !== e)
        begin
            errors++;
            $display("Error %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic fr(input logic [15:0] tx, input int n);
        ssr_spi_master_i.xfer(tx, n, r);
    endtask
    task automatic t_zero;
        fr(16'h0, 0);
        chk("por flag", 8'h01, {7'h0, r[0]});
        por_done_in = 1'b1;
        fr(16'h0, 0);
        chk("idle flag", 8'h00, {7'h0, r[0]});
        $display("t_zero done");
    endtask
    task automatic t_stat;
        glob_misc_in = 5'h03;
        fr(16'h0137, 16);
        chk("gstat", 8'h0f, {4'h0, r[3:0]});
        chk("resp", 8'h00, r[15:8]);
        glob_misc_in = 5'h00;
        $display("t_stat done");
    endtask
    task automatic t_fault;
        fork
            fr(16'h01b7, 16);
            begin
                // Lands in the data byte of the clearing frame
                repeat (140) @(negedge clk_sys_in);
                fault_set_in[0] = 8'h02;
                repeat (4) @(negedge clk_sys_in);
                fault_set_in[0] = 8'h00;
            end
        join
        chk("resp new", 8'h02, r[15:8]);
        chk("le old", 8'h00, {7'h0, r[6]});
        chk("kept", 8'h02, stat[0]);
        chk("le out", 8'h01, {7'h0, lerr});
        fr(16'h0137, 16);
        chk("le next", 8'h01, {7'h0, r[6]});
        chk("resp old", 8'h02, r[15:8]);
        fr(16'h01b7, 16);
        chk("cleared", 8'h00, stat[0]);
        fr(16'h0, 0);
        chk("flag off", 8'h00, {7'h0, r[0]});
        chk("le off", 8'h00, {7'h0, lerr});
        $display("t_fault done");
    endtask
    task automatic t_prot;
        fr(16'h0136, 16);
        fr(16'h0137, 16);
        chk("err bit", 8'h01, {7'h0, r[7]});
        chk("err out", 8'h01, {7'h0, perr});
        chk("err flag", 8'h01, {7'h0, gerr});
        fr(16'h01b3, 16);
        chk("err clr", 8'h00, {7'h0, perr});
        $display("t_prot done");
    endtask
    task automatic stop_test;
        $display("Checks %0d mismatches %0d", n_tests, errors);
        if (errors == 0 && n_tests > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    initial
    begin
        clk_sys_in = 1'b0;
        forever #2.5 clk_sys_in = ~clk_sys_in;
    end
    initial
    begin
        nrst_in = 1'b0;
        fault_set_in = '0;
        glob_misc_in = '0;
        por_done_in = 1'b0;
        repeat (12) @(negedge clk_sys_in);
        nrst_in = 1'b1;
        repeat (8) @(negedge clk_sys_in);
        t_zero;
        t_stat;
        t_fault;
        t_prot;
        stop_test;
    end
    // Ten frames need about 2150 cycles
    initial
    begin
        repeat (40000) @(posedge clk_sys_in);
        errors++;
        stop_test;
    end
endmodule // ssr_status_slave_test
